// [core/ewg_pkg.sv]
// Constants and types of the write guard of a serial memory.
// Assumes one compile unit in which the package comes first.
package ewg_pkg;

  // ==========================================================
  // Command bytes
  localparam logic [7:0] CMD_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] CMD_WRITE_DISABLE = 8'h04;
  localparam logic [7:0] CMD_WRITE_STATUS = 8'h01;
  localparam logic [3:0] CMD_ARRAY_HI = 4'h0;
  localparam logic [2:0] CMD_ARRAY_WRITE_LO = 3'h2;
  localparam int OP_ADDR_MSB_POS = 3;

  // ==========================================================
  // Frame lengths in whole bytes, and first and last bit positions within a byte
  localparam logic [4:0] LEN_SINGLE = 5'h01;
  localparam logic [4:0] LEN_STATUS = 5'h02;
  localparam logic [4:0] LEN_WRITE_MIN = 5'h03;
  localparam logic [4:0] LEN_SAT = 5'h1F;
  localparam logic [2:0] BIT_FIRST = 3'h0;
  localparam logic [2:0] BIT_LAST = 3'h7;

  // ==========================================================
  // Block protection levels, encoded in declaration order
  typedef enum logic [1:0] {
    EWG_PROT_NONE,
    EWG_PROT_QUARTER,
    EWG_PROT_HALF,
    EWG_PROT_ALL
  } ewg_prot_t;
  localparam logic [8:0] PROT_QUARTER_BASE = 9'h180;
  localparam logic [8:0] PROT_HALF_BASE = 9'h100;

  // ==========================================================
  // Synchroniser lanes and reset values
  localparam int SYN_CS = 0;
  localparam int SYN_WP = 1;
  localparam int SYN_TOG = 2;
  localparam int SYN_W = 3;
  localparam logic [2:0] SYN_RST = 3'h1;
  localparam logic RST_CS_N = 1'b1;
  localparam logic RST_FLAG = 1'b0;

endpackage

// [core/ewg_sync.sv]
// Multi-bit level synchroniser with a two-sample agreement filter.
// Assumes each lane is an independent level from another domain.
module ewg_sync #(
  parameter int W = 3,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Asynchronous levels in, filtered levels out
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_level
);

  // ==========================================================
  // Three stages per lane; the output moves once stages two
  // and three agree
  for (genvar g = 0; g < W; g++) begin : g_lane
    logic s1_q;
    logic s2_q;
    logic s3_q;
    logic lvl_q;
    logic lvl_d;

    always_comb begin
      lvl_d = (s2_q == s3_q) ? s3_q : lvl_q;
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
        s1_q <= RST_VAL[g];
        s2_q <= RST_VAL[g];
        s3_q <= RST_VAL[g];
        lvl_q <= RST_VAL[g];
      end else begin
        s1_q <= i_async[g];
        s2_q <= s1_q;
        s3_q <= s2_q;
        lvl_q <= lvl_d;
      end
    end

    assign o_level[g] = lvl_q;
  end

endmodule

// [core/ewg_top.sv]
// Write guard: write latch flag, write cycle start and refusal.
// Assumes the serial clock stops outside frames, array logic on
// the reference clock, and stable protect bits during a frame.
module ewg_top (
  // Reference clock and reset
  input wire logic I_REF_CLK,
  input wire logic I_NRST,
  // Serial link
  input wire logic I_SCK,
  input wire logic I_CS_N,
  input wire logic I_SI,
  input wire logic I_WP_N,
  output logic O_SO,
  output logic O_SO_OE,
  // Array and status register side
  input wire logic I_BLOCK_PROTECT_HIGH,
  input wire logic I_BLOCK_PROTECT_LOW,
  input wire logic I_WRITE_DONE,
  input wire logic I_SO_EN,
  input wire logic I_SO_DATA,
  // Guard state
  output logic O_SELECTED,
  output logic O_WRITE_LATCH_FLAG,
  output logic O_WRITE_BUSY,
  output logic O_WRITE_START,
  output logic O_WRITE_STATUS,
  output logic [8:0] O_WRITE_ADDR,
  output logic O_WRITE_REFUSED
);

  // ==========================================================
  // Reset release
  logic rst_meta_q;
  logic rst_n_q;

  always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      rst_meta_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q <= rst_meta_q;
    end
  end

  // ==========================================================
  // Link domain: bit and byte counting within one frame
  logic sck_clr_n;
  logic [2:0] bit_cnt_q;
  logic [2:0] bit_cnt_d;
  logic [4:0] byte_cnt_q;
  logic [4:0] byte_cnt_d;
  logic [6:0] shift_q;
  logic [6:0] shift_d;
  logic [7:0] byte_in;

  // Deselect clears the counters, so each frame starts at bit 0
  assign sck_clr_n = rst_n_q & ~I_CS_N;

  always_comb begin
    byte_in = {shift_q, I_SI};
    bit_cnt_d = bit_cnt_q + 3'h1;
    shift_d = byte_in[6:0];
    byte_cnt_d = byte_cnt_q;
    if (bit_cnt_q == ewg_pkg::BIT_LAST &&
        byte_cnt_q != ewg_pkg::LEN_SAT) begin
      byte_cnt_d = byte_cnt_q + 5'h01;
    end
  end

  always_ff @(posedge I_SCK or negedge sck_clr_n) begin
    if (!sck_clr_n) begin
      bit_cnt_q <= '0;
      byte_cnt_q <= '0;
      shift_q <= '0;
    end else begin
      bit_cnt_q <= bit_cnt_d;
      byte_cnt_q <= byte_cnt_d;
      shift_q <= shift_d;
    end
  end

  // ==========================================================
  // Link domain: frame results, held after deselect
  logic [7:0] op_q;
  logic [7:0] op_d;
  logic [7:0] adr_q;
  logic [7:0] adr_d;
  logic [4:0] nbytes_q;
  logic [4:0] nbytes_d;
  logic odd_q;
  logic odd_d;
  logic tog_q;
  logic tog_d;

  always_comb begin
    op_d = op_q;
    adr_d = adr_q;
    if (bit_cnt_q == ewg_pkg::BIT_LAST && byte_cnt_q == '0) begin
      op_d = byte_in;
    end
    if (bit_cnt_q == ewg_pkg::BIT_LAST &&
        byte_cnt_q == ewg_pkg::LEN_SINGLE) begin
      adr_d = byte_in;
    end
    nbytes_d = byte_cnt_d;
    // Any bit past a byte boundary marks the frame as misaligned
    odd_d = (bit_cnt_q != ewg_pkg::BIT_LAST);
    // Toggle on the first edge so an edgeless frame is not replayed
    tog_d = tog_q;
    if (bit_cnt_q == ewg_pkg::BIT_FIRST && byte_cnt_q == '0) begin
      tog_d = ~tog_q;
    end
  end

  always_ff @(posedge I_SCK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      op_q <= '0;
      adr_q <= '0;
      nbytes_q <= '0;
      odd_q <= 1'b0;
      tog_q <= 1'b0;
    end else begin
      op_q <= op_d;
      adr_q <= adr_d;
      nbytes_q <= nbytes_d;
      odd_q <= odd_d;
      tog_q <= tog_d;
    end
  end

  // ==========================================================
  // Pin and toggle crossing into the reference domain
  logic [ewg_pkg::SYN_W-1:0] syn_lvl;
  logic cs_n_lvl;
  logic wp_hi;
  logic tog_lvl;

  ewg_sync #(
    .W(ewg_pkg::SYN_W),
    .RST_VAL(ewg_pkg::SYN_RST)
  ) u_sync (
    .i_clk(I_REF_CLK),
    .i_rst_n(rst_n_q),
    .i_async({tog_q, I_WP_N, I_CS_N}),
    .o_level(syn_lvl)
  );

  // Select reads as high and protect pin as low until sampled
  assign cs_n_lvl = syn_lvl[ewg_pkg::SYN_CS];
  assign wp_hi = syn_lvl[ewg_pkg::SYN_WP];
  assign tog_lvl = syn_lvl[ewg_pkg::SYN_TOG];

  // ==========================================================
  // Reference domain: decode at deselect and guard the writes
  logic frame_end;
  logic fresh;
  logic is_write_enable_command;
  logic is_write_disable_command;
  logic is_wrsr;
  logic is_write;
  logic [8:0] addr;
  logic blocked;
  logic allowed;
  logic dec_ok;
  ewg_pkg::ewg_prot_t prot;
  logic cs_prev_q;
  logic tog_seen_q;
  logic tog_seen_d;
  logic selected_q;
  logic selected_d;
  logic flag_q;
  logic flag_d;
  logic busy_q;
  logic busy_d;
  logic start_q;
  logic start_d;
  logic status_q;
  logic status_d;
  logic [8:0] waddr_q;
  logic [8:0] waddr_d;
  logic refused_q;
  logic refused_d;
  logic so_q;
  logic so_d;
  logic so_oe_q;
  logic so_oe_d;

  // Link results are read only once the select is seen high, when
  // the serial clock has stopped and they no longer move
  assign frame_end = cs_n_lvl & ~cs_prev_q;
  assign fresh = tog_lvl ^ tog_seen_q;
  assign dec_ok = frame_end & fresh & ~busy_q;
  assign addr = {op_q[ewg_pkg::OP_ADDR_MSB_POS], adr_q};
  assign prot = ewg_pkg::ewg_prot_t'({I_BLOCK_PROTECT_HIGH,
                                      I_BLOCK_PROTECT_LOW});
  assign allowed = flag_q & wp_hi & ~(is_write & blocked);

  // ==========================================================
  // Command decode: whole bytes only, exact frame lengths except array writes of three bytes or more
  always_comb begin
    is_write_enable_command = !odd_q && op_q == ewg_pkg::CMD_WRITE_ENABLE &&
              nbytes_q == ewg_pkg::LEN_SINGLE;
    is_write_disable_command = !odd_q && op_q == ewg_pkg::CMD_WRITE_DISABLE &&
              nbytes_q == ewg_pkg::LEN_SINGLE;
    is_wrsr = !odd_q && op_q == ewg_pkg::CMD_WRITE_STATUS &&
              nbytes_q == ewg_pkg::LEN_STATUS;
    is_write = !odd_q && op_q[7:4] == ewg_pkg::CMD_ARRAY_HI &&
               op_q[2:0] == ewg_pkg::CMD_ARRAY_WRITE_LO &&
               nbytes_q >= ewg_pkg::LEN_WRITE_MIN;
  end

  // Protected range from the block-protect pair
  always_comb begin
    unique case (prot)
      ewg_pkg::EWG_PROT_NONE: blocked = 1'b0;
      ewg_pkg::EWG_PROT_QUARTER: blocked = addr >= ewg_pkg::PROT_QUARTER_BASE;
      ewg_pkg::EWG_PROT_HALF: blocked = addr >= ewg_pkg::PROT_HALF_BASE;
      ewg_pkg::EWG_PROT_ALL: blocked = 1'b1;
    endcase
  end

  // ==========================================================
  // Guard state: later clauses win, so a low protect pin has the
  // last word over any set
  always_comb begin
    tog_seen_d = tog_seen_q;
    selected_d = ~cs_n_lvl;
    flag_d = flag_q;
    busy_d = busy_q;
    start_d = 1'b0;
    status_d = status_q;
    waddr_d = waddr_q;
    refused_d = 1'b0;
    so_d = I_SO_DATA;
    so_oe_d = ~cs_n_lvl & I_SO_EN;
    if (frame_end) begin
      tog_seen_d = tog_lvl;
    end
    if (dec_ok && is_write_enable_command && wp_hi) begin
      flag_d = 1'b1;
    end
    if (dec_ok && is_write_disable_command) begin
      flag_d = 1'b0;
    end
    if (dec_ok && (is_write || is_wrsr)) begin
      if (allowed) begin
        busy_d = 1'b1;
        start_d = 1'b1;
        status_d = is_wrsr;
        waddr_d = addr;
      end else begin
        refused_d = 1'b1;
      end
    end
    if (busy_q && I_WRITE_DONE) begin
      busy_d = 1'b0;
      flag_d = 1'b0;
    end
    if (!wp_hi) begin
      flag_d = 1'b0;
    end
  end

  always_ff @(posedge I_REF_CLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      cs_prev_q <= ewg_pkg::RST_CS_N;
      tog_seen_q <= 1'b0;
      selected_q <= 1'b0;
      flag_q <= ewg_pkg::RST_FLAG;
      busy_q <= 1'b0;
      start_q <= 1'b0;
      status_q <= 1'b0;
      waddr_q <= '0;
      refused_q <= 1'b0;
      so_q <= 1'b0;
      so_oe_q <= 1'b0;
    end else begin
      cs_prev_q <= cs_n_lvl;
      tog_seen_q <= tog_seen_d;
      selected_q <= selected_d;
      flag_q <= flag_d;
      busy_q <= busy_d;
      start_q <= start_d;
      status_q <= status_d;
      waddr_q <= waddr_d;
      refused_q <= refused_d;
      so_q <= so_d;
      so_oe_q <= so_oe_d;
    end
  end

  assign O_SELECTED = selected_q;
  assign O_WRITE_LATCH_FLAG = flag_q;
  assign O_WRITE_BUSY = busy_q;
  assign O_WRITE_START = start_q;
  assign O_WRITE_STATUS = status_q;
  assign O_WRITE_ADDR = waddr_q;
  assign O_WRITE_REFUSED = refused_q;
  assign O_SO = so_q;
  assign O_SO_OE = so_oe_q;

  // ==========================================================
  // Guard checks
  a_wp_clears: assert property (
    @(posedge I_REF_CLK) disable iff (!rst_n_q)
    !wp_hi |=> !flag_q)
    else $error("latch flag set while protect pin low");
  a_write_enable_command_sets: assert property (
    @(posedge I_REF_CLK) disable iff (!rst_n_q)
    dec_ok && is_write_enable_command && wp_hi |=> flag_q)
    else $error("write enable did not set latch flag");
  a_write_disable_command_clears: assert property (
    @(posedge I_REF_CLK) disable iff (!rst_n_q)
    dec_ok && is_write_disable_command |=> !flag_q)
    else $error("write disable did not clear latch flag");
  a_refuse_write: assert property (
    @(posedge I_REF_CLK) disable iff (!rst_n_q)
    dec_ok && (is_write || is_wrsr) && !allowed |=> refused_q && !start_q)
    else $error("unguarded write was started");
  a_protect_block: assert property (
    @(posedge I_REF_CLK) disable iff (!rst_n_q)
    dec_ok && is_write && blocked |=> !start_q)
    else $error("write to protected block was started");
  a_busy_holds: assert property (
    @(posedge I_REF_CLK) disable iff (!rst_n_q)
    busy_q && !I_WRITE_DONE |=> busy_q && !start_q)
    else $error("write cycle disturbed");
  a_done_clears: assert property (
    @(posedge I_REF_CLK) disable iff (!rst_n_q)
    busy_q && I_WRITE_DONE |=> !flag_q && !busy_q)
    else $error("completed write left latch flag set");
  a_so_quiet: assert property (
    @(posedge I_REF_CLK) disable iff (!rst_n_q)
    !selected_q |-> !so_oe_q)
    else $error("serial output driven while deselected");
endmodule

// [verification/ewg_host.sv]
// Behavioural serial host that frames bytes toward the write guard.
// Assumes mode 0 timing: clock idles low, data set up on falling edges.
module ewg_host (
  // Serial link driven toward the device
  output logic o_sck,
  output logic o_cs_n,
  output logic o_si
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    o_sck = 1'b0;
    o_cs_n = 1'b1;
    o_si = 1'b0;
  end

  // ==========================================================
  // Frame: the clock only runs while selected, MSB first
  task automatic frame(input logic [23:0] d, input int nbits);
    o_cs_n = 1'b0;
    #40;
    for (int i = nbits - 1; i >= 0; i--) begin
      o_si = d[i];
      #40 o_sck = 1'b1;
      #40 o_sck = 1'b0;
    end
    #40 o_cs_n = 1'b1;
    o_si = ~o_si;
    // Stay deselected long enough for the select to be seen high
    #160;
  endtask
endmodule

// [verification/testbench.sv]
// Self-checking bench of the write guard with a serial host model.
// Assumes the host model drives the link on its own 80 ns clock.
module testbench;
  timeunit 1ns;
  timeprecision 100ps;

  logic clk, nrst, wp_n, bph, bpl, done, so_en, so_d;
  logic sck, cs_n, si, so, so_oe, sel, flag, busy, start, wst, refd;
  logic [8:0] waddr;
  logic [7:0] rnd;
  logic q[$];
  logic e;
  int n_errors, checked;
  int n_ref, n_start;
  event ev;

  ewg_host i_ewg_host (.o_sck(sck), .o_cs_n(cs_n), .o_si(si));
  ewg_top i_ewg_top (.I_REF_CLK(clk), .I_NRST(nrst), .I_SCK(sck),
    .I_CS_N(cs_n), .I_SI(si), .I_WP_N(wp_n), .O_SO(so), .O_SO_OE(so_oe),
    .I_BLOCK_PROTECT_HIGH(bph), .I_BLOCK_PROTECT_LOW(bpl),
    .I_WRITE_DONE(done), .I_SO_EN(so_en), .I_SO_DATA(so_d),
    .O_SELECTED(sel), .O_WRITE_LATCH_FLAG(flag), .O_WRITE_BUSY(busy),
    .O_WRITE_START(start), .O_WRITE_STATUS(wst), .O_WRITE_ADDR(waddr),
    .O_WRITE_REFUSED(refd));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  task automatic cmp(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // ==========================================================
  // Notes an expected flag, then lets the monitor compare it
  task automatic expect_flag(input logic x);
    repeat (20) @(negedge clk);
    q.push_back(x);
    ->ev;
  endtask

  always @(negedge clk) begin
    if (refd === 1'b1) n_ref++;
    if (start === 1'b1) n_start++;
  end

  initial forever begin
    @(ev);
    e = q.pop_front();
    cmp(flag, e);
  end

  task automatic tally_and_finish;
    $display("errors=%0d checks=%0d", n_errors, checked);
    if (n_errors == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial begin
    #100us;
    n_errors++;
    tally_and_finish();
  end

  // ==========================================================
  // Main sequence
  initial begin
    {nrst, done, so_en} = 3'h0;
    wp_n = 1'b1;
    rnd = 8'h58;
    {bph, bpl, so_d} = rnd[2:0];
    repeat (4) @(negedge clk);
    nrst = 1'b1;
    repeat (4) @(negedge clk);
    cmp(so_oe, 1'b0);
    cmp(sel, 1'b0);
    cmp(so, 1'b0);
    expect_flag(1'b0);
    i_ewg_host.frame(24'h00_0006, 8);
    expect_flag(1'b1);
    i_ewg_host.frame(24'h00_0004, 8);
    expect_flag(1'b0);
    rnd = lfsr(rnd);
    i_ewg_host.frame(24'h00_0006, 8);
    i_ewg_host.frame({8'h00, 8'h01, rnd} >> 1, 15);
    expect_flag(1'b1);
    i_ewg_host.frame({8'h00, 8'h01, rnd}, 16);
    repeat (10) @(negedge clk);
    cmp(busy, 1'b1);
    cmp(wst, 1'b1);
    done = 1'b1;
    @(negedge clk);
    done = 1'b0;
    expect_flag(1'b0);
    {bph, bpl} = 2'b01;
    i_ewg_host.frame(24'h00_0006, 8);
    i_ewg_host.frame({8'h0A, 8'hA0, rnd}, 24);
    expect_flag(1'b1);
    cmp(n_ref == 1, 1'b1);
    i_ewg_host.frame({8'h02, 8'hA0, rnd}, 24);
    repeat (10) @(negedge clk);
    cmp(busy, 1'b1);
    cmp(waddr == 9'h0A0, 1'b1);
    cmp(wst, 1'b0);
    i_ewg_host.frame({8'h02, 8'h10, rnd}, 24);
    repeat (10) @(negedge clk);
    cmp(n_start == 2, 1'b1);
    cmp(waddr == 9'h0A0, 1'b1);
    done = 1'b1;
    @(negedge clk);
    done = 1'b0;
    expect_flag(1'b0);
    i_ewg_host.frame(24'h00_0006, 8);
    @(negedge clk);
    wp_n = 1'b0;
    expect_flag(1'b0);
    i_ewg_host.frame(24'h00_0006, 8);
    expect_flag(1'b0);
    @(negedge clk);
    wp_n = 1'b1;
    repeat (5) @(negedge clk);
    i_ewg_host.frame({8'h02, 8'h00, rnd}, 24);
    repeat (10) @(negedge clk);
    cmp(n_ref == 2, 1'b1);
    cmp(n_start == 2, 1'b1);
    tally_and_finish();
  end
endmodule
